// *** rtl/tcw_defs.svh ***
// constants for the memory write path with check-bit generation
// assumes one clock, synchronous active-high reset
// Operation
// - memory and check bits not cleared at reset
// - check bits always written, checking on or off
// - checked reads need whole aligned chunks first
// - parity scheme: any slave write allowed
// - 32-bit ecc: word aligned, full strobes (code ignores the scheme field; no slave write faults)
// - 64-bit ecc: doubleword aligned, full strobes (code ignores the scheme field; no slave write faults)
// - 64-bit store mode: partial writes use rmw
// - check and store mode held per interface
// - doubleword or multiple stores fault unless word aligned
// - strict alignment also faults unaligned word stores
// - no error reported during invalidate-all
// - software enables checking before invalidating cache
// - slave clock enable on coinciding clock edges
`ifndef TCW_DEFS_SVH
`define TCW_DEFS_SVH
`define TCW_SCH_PARITY 2'h0
`define TCW_SCH_ECC32 2'h1
`define TCW_SCH_ECC64 2'h2
`define TCW_SIZE_BYTE 2'h0
`define TCW_SIZE_HALF 2'h1
`define TCW_SIZE_WORD 2'h2
`define TCW_SIZE_DWORD 2'h3
`define TCW_KIND_STORE 2'h0
`define TCW_KIND_DWORD 2'h1
`define TCW_KIND_MULTI 2'h2
`define TCW_KIND_AXI 2'h3
`define TCW_ADDR_W 16
`define TCW_WORD_LSB 2
`define TCW_DW_LSB 3
`define TCW_ST_INT 0
`define TCW_ST_FAULT 1
`define TCW_ST_ERR 2
`endif

// *** rtl/tcw_pkg.sv ***
// state type used inside the memory write path
// assumes tcw_defs.svh is compiled alongside
package tcw_pkg;
   typedef enum logic [2:0] {
      TCW_IDLE = 3'b001,
      TCW_READ = 3'b010,
      TCW_WRITE = 3'b100
   } tcw_state_e;
endpackage

// *** rtl/tcw_if.sv ***
// request link between the write source and the memory write path
// assumes both ends on one clock
`timescale 1ns/1ns
`default_nettype none
interface tcw_if;
   logic req;
   logic [1:0] kind;
   logic [1:0] size;
   logic [15:0] addr;
   logic [63:0] wdata;
   logic [7:0] strb;
   logic slave_port_clock_enable;
   logic rd;
   logic done;
   logic fault;
   logic [63:0] rdata;
   logic err;
   modport dev (input req, kind, size, addr, wdata, strb,
      slave_port_clock_enable, rd, output done, fault, rdata, err);
   modport src (output req, kind, size, addr, wdata, strb,
      slave_port_clock_enable, rd, input done, fault, rdata, err);
endinterface
`default_nettype wire

// *** rtl/tcw_src.sv ***
// write source: turns user orders into link requests
// assumes the write path answers with done within a few cycles
`include "tcw_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module tcw_src
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // user orders
   input wire logic go_i,
   input wire logic rd_i,
   input wire logic [1:0] kind_i,
   input wire logic [1:0] size_i,
   input wire logic [15:0] addr_i,
   input wire logic [63:0] wdata_i,
   input wire logic [7:0] strb_i,
   input wire logic axi_clk_en_i,
   // results
   output logic busy_o,
   output logic done_o,
   output logic fault_o,
   output logic err_o,
   output logic [63:0] rdata_o,
   // link
   tcw_if.src lnk
);
   logic [1:0] kind_r;
   logic [1:0] size_r;
   logic [15:0] addr_r;
   logic [63:0] wdata_r;
   logic [7:0] strb_r;
   logic rd_r;
   logic en_r;
   assign lnk.req = busy_o;
   assign lnk.kind = kind_r;
   assign lnk.size = size_r;
   assign lnk.addr = addr_r;
   assign lnk.wdata = wdata_r;
   assign lnk.strb = strb_r;
   assign lnk.rd = rd_r;
   assign lnk.slave_port_clock_enable = en_r;
   // enable comes from same-clock logic; pass it per edge
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         en_r <= 1'b1;
      else
         en_r <= axi_clk_en_i;
   end
   // hold the request until done
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         busy_o <= 1'b0;
         kind_r <= `TCW_KIND_STORE;
         size_r <= `TCW_SIZE_WORD;
         addr_r <= '0;
         wdata_r <= '0;
         strb_r <= '0;
         rd_r <= 1'b0;
      end
      else if (!busy_o && go_i)
      begin
         busy_o <= 1'b1;
         kind_r <= kind_i;
         size_r <= size_i;
         addr_r <= addr_i;
         wdata_r <= wdata_i;
         strb_r <= strb_i;
         rd_r <= rd_i;
      end
      else if (busy_o && lnk.done)
         busy_o <= 1'b0;
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         done_o <= 1'b0;
         fault_o <= 1'b0;
         err_o <= 1'b0;
         rdata_o <= '0;
      end
      else
      begin
         done_o <= busy_o && lnk.done;
         fault_o <= busy_o && lnk.done && lnk.fault;
         err_o <= busy_o && lnk.done && lnk.err;
         if (busy_o && lnk.done)
            rdata_o <= lnk.rdata;
      end
   end
endmodule
`default_nettype wire

// *** rtl/tcw_dev.sv ***
// memory write path with check-bit generation, plus wishbone control
// assumes source holds each request until done; one clock domain
//
// Implementation choices: the register addresses and the Wishbone interface to the registers.
`include "tcw_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module tcw_dev
#(
   parameter int DEPTH = 256
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic irq_o,
   // cache maintenance
   input wire logic inval_all_i,
   // link
   tcw_if.dev lnk
);
   // register byte addresses: control, status, mask
   localparam logic [3:0] A_CTRL = 4'h0;
   localparam logic [3:0] A_STAT = 4'h4;
   localparam logic [3:0] A_MASK = 4'h8;
   localparam int AW = $clog2(DEPTH);
   // ctrl: [1:0] scheme, [2] check en, [3] 64-bit store, [4] strict align
   logic [4:0] ctrl_r;
   logic [2:0] stat_r;
   logic [2:0] mask_r;
   tcw_pkg::tcw_state_e st_r;
   // data and check bits, never cleared
   logic [63:0] mem [DEPTH];
   logic [7:0] chk [DEPTH];
   logic [63:0] old_r;
   logic [7:0] oldc_r;
   logic [AW-1:0] idx;
   logic mis_word;
   logic fault;
   logic rmw;
   logic [63:0] merged;
   logic [7:0] newc;
   logic chk_bad;
   logic ev_err;
   logic ev_fault;
   logic wb_acc;
   logic wb_wr;
   assign idx = lnk.addr[`TCW_DW_LSB +: AW];
   assign mis_word = |lnk.addr[`TCW_WORD_LSB-1:0];
   always_comb
   begin
      fault = 1'b0;
      if (lnk.kind == `TCW_KIND_DWORD || lnk.kind == `TCW_KIND_MULTI)
         fault = mis_word;
      else if (lnk.kind == `TCW_KIND_STORE && lnk.size == `TCW_SIZE_WORD)
         fault = ctrl_r[4] && mis_word;
      if (lnk.rd)
         fault = 1'b0;
   end
   // rmw merges old bytes under disabled strobes
   // narrow or unaligned writes go through rmw as well
   assign rmw = ctrl_r[3] && (lnk.strb != 8'hff
      || lnk.size != `TCW_SIZE_DWORD || |lnk.addr[`TCW_DW_LSB-1:0]);
   always_comb
   begin
      for (int b = 0; b < 8; b++)
         merged[b*8 +: 8] = (rmw && !lnk.strb[b]) ? old_r[b*8 +: 8]
            : lnk.wdata[b*8 +: 8];
   end
   // one parity bit per byte lane; without rmw, lanes with strobe off keep the old bit
   always_comb
   begin
      for (int b = 0; b < 8; b++)
         newc[b] = (rmw || lnk.strb[b]) ? ^merged[b*8 +: 8] : oldc_r[b];
   end
   // check all eight byte lanes against their parity bits
   always_comb
   begin
      chk_bad = 1'b0;
      for (int b = 0; b < 8; b++)
         if (^old_r[b*8 +: 8] != oldc_r[b])
            chk_bad = 1'b1;
   end
   // checking per interface only; muted during invalidate-all
   assign ev_err = st_r == tcw_pkg::TCW_READ && lnk.rd && ctrl_r[2]
      && chk_bad && !inval_all_i;
   assign ev_fault = st_r == tcw_pkg::TCW_IDLE && lnk.req
      && lnk.slave_port_clock_enable && fault;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_r <= tcw_pkg::TCW_IDLE;
         lnk.done <= 1'b0;
         lnk.fault <= 1'b0;
         lnk.err <= 1'b0;
         lnk.rdata <= '0;
         old_r <= '0;
         oldc_r <= '0;
      end
      else
      begin
         lnk.done <= 1'b0;
         unique case (st_r)
            tcw_pkg::TCW_IDLE:
               // take requests only on enabled edges
               if (lnk.req && lnk.slave_port_clock_enable && !lnk.done)
               begin
                  if (fault)
                  begin
                     lnk.fault <= 1'b1;
                     lnk.err <= 1'b0;
                     lnk.done <= 1'b1;
                  end
                  else
                  begin
                     old_r <= mem[idx];
                     oldc_r <= chk[idx];
                     st_r <= tcw_pkg::TCW_READ;
                  end
               end
            tcw_pkg::TCW_READ:
               if (lnk.rd)
               begin
                  lnk.rdata <= old_r;
                  lnk.err <= ev_err;
                  lnk.fault <= 1'b0;
                  lnk.done <= 1'b1;
                  st_r <= tcw_pkg::TCW_IDLE;
               end
               else
                  st_r <= tcw_pkg::TCW_WRITE;
            tcw_pkg::TCW_WRITE:
            begin
               lnk.fault <= 1'b0;
               lnk.err <= 1'b0;
               lnk.done <= 1'b1;
               st_r <= tcw_pkg::TCW_IDLE;
            end
         endcase
      end
   end
   always_ff @(posedge clk_i)
   begin
      if (st_r == tcw_pkg::TCW_WRITE)
      begin
         mem[idx] <= merged;
         chk[idx] <= newc;
      end
   end
   assign wb_acc = cyc_i && stb_i && !ack_o;
   // writes land at the edge where the master sees ack
   assign wb_wr = cyc_i && stb_i && we_i && sel_i[0] && ack_o;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_r <= '0;
         mask_r <= '0;
      end
      else if (wb_wr)
      begin
         if (adr_i == A_CTRL)
            ctrl_r <= dat_i[4:0];
         if (adr_i == A_MASK)
            mask_r <= dat_i[2:0];
      end
   end
   // set wins over write-one clear
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         stat_r <= '0;
      else
      begin
         for (int i = 0; i < 3; i++)
            if (wb_wr && adr_i == A_STAT && dat_i[i])
               stat_r[i] <= 1'b0;
         if (ev_fault)
            stat_r[`TCW_ST_FAULT] <= 1'b1;
         if (ev_err)
            stat_r[`TCW_ST_ERR] <= 1'b1;
         if (st_r == tcw_pkg::TCW_WRITE && rmw)
            stat_r[`TCW_ST_INT] <= 1'b1;
      end
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         dat_o <= '0;
         irq_o <= 1'b0;
      end
      else
      begin
         ack_o <= wb_acc;
         irq_o <= |(stat_r & mask_r);
         unique case (adr_i)
            A_CTRL: dat_o <= {27'h0, ctrl_r};
            A_STAT: dat_o <= {29'h0, stat_r};
            A_MASK: dat_o <= {29'h0, mask_r};
            default: dat_o <= '0;
         endcase
      end
   end
endmodule
`default_nettype wire

// *** testbench/tcw_link_sva.sv ***
// assertions on the link between write source and write path
// assumes it sits beside the interface, one clock, sync high reset
`include "tcw_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module tcw_link_sva
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // link and maintenance
   input wire logic req,
   input wire logic [1:0] kind,
   input wire logic [15:0] addr,
   input wire logic slave_port_clock_enable,
   input wire logic rd,
   input wire logic done,
   input wire logic fault,
   input wire logic err,
   input wire logic [63:0] rdata,
   input wire logic inval_all_i
);
   logic pend_r;
   logic taken;
   logic odd;
   // a request counts once, from acceptance until its answer
   assign taken = req && slave_port_clock_enable && !done && !pend_r;
   assign odd = addr[1:0] != 2'h0;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         pend_r <= 1'b0;
      else if (taken)
         pend_r <= 1'b1;
      else if (done)
         pend_r <= 1'b0;
   end
   default clocking dcb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   fault_lat_a: assert property (taken && !rd && odd &&
      kind inside {`TCW_KIND_DWORD, `TCW_KIND_MULTI} |=> done && fault)
      else $error("misaligned multi store not faulted");
   no_dw_chk_a: assert property (taken && !rd && !odd &&
      kind == `TCW_KIND_DWORD |=> !done [*2] ##1 (done && !fault))
      else $error("word aligned dword store faulted");
   axi_wr_a: assert property (taken && !rd && kind == `TCW_KIND_AXI
      |-> ##3 (done && !fault)) else $error("slave write answer wrong");
   read_lat_a: assert property (taken && rd |=> !done ##1 done)
      else $error("read answer late or early");
   done_pulse_a: assert property (done |=> !done)
      else $error("done longer than one cycle");
   inval_err_a: assert property (done && inval_all_i |-> !err)
      else $error("error reported during invalidate");
   rdata_hold_a: assert property (!done |-> $stable(rdata))
      else $error("read data changed without answer");
   stat_hold_a: assert property (!done |-> $stable({fault, err}))
      else $error("fault or error changed without answer");
   en_gate_a: assert property (req && !slave_port_clock_enable
      && !pend_r |=> !done) else $error("request served without enable");
   cover property (taken && rd);
   cover property (done && fault);
   cover property (req && !slave_port_clock_enable);
   cover property (done && err);
endmodule
`default_nettype wire

// *** testbench/tcw_tb_top.sv ***
// self-checking bench: source and write path joined by the link
// assumes 50 MHz clock, sync high reset, small memory depth
`include "tcw_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module tcw_tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic go_i = 1'b0, rd_i = 1'b0, en_i = 1'b1, inval_i = 1'b0;
   logic [1:0] kind_i = 2'h0, size_i = 2'h0;
   logic [15:0] addr_i = 16'h0;
   logic [63:0] wdata_i = 64'h0, d1, d2;
   logic [7:0] strb_i = 8'h0;
   logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [3:0] adr_i = 4'h0, sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, wbr, dat_o;
   logic busy_o, done_o, fault_o, err_o, ack_o, irq_o;
   logic [63:0] rdata_o;
   logic [31:0] lfsr_r = 32'he20ef1b7;
   logic [66:0] exp_q[$];
   logic [66:0] e;
   int error_cnt = 0;
   int total_checks = 0;
   // {fault if strict or not single, kind, size, byte address}
   logic [12:0] tbl [6] = '{13'h170a, 13'h1a11, 13'h070c, 13'h1202,
      13'h0003, 13'h0106};
   always #10 clk_i = ~clk_i;
   tcw_if tcw_if_inst ();
   tcw_src tcw_src_inst (.clk_i(clk_i), .rst_i(rst_i), .go_i(go_i),
      .rd_i(rd_i), .kind_i(kind_i), .size_i(size_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .strb_i(strb_i), .axi_clk_en_i(en_i),
      .busy_o(busy_o), .done_o(done_o), .fault_o(fault_o), .err_o(err_o),
      .rdata_o(rdata_o), .lnk(tcw_if_inst.src));
   tcw_dev #(.DEPTH(16)) tcw_dev_inst (.clk_i(clk_i), .rst_i(rst_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .irq_o(irq_o), .inval_all_i(inval_i), .lnk(tcw_if_inst.dev));
   tcw_link_sva tcw_link_sva_inst (.clk_i(clk_i), .rst_i(rst_i),
      .req(tcw_if_inst.req), .kind(tcw_if_inst.kind),
      .addr(tcw_if_inst.addr), .rd(tcw_if_inst.rd),
      .slave_port_clock_enable(tcw_if_inst.slave_port_clock_enable),
      .done(tcw_if_inst.done), .fault(tcw_if_inst.fault),
      .err(tcw_if_inst.err), .rdata(tcw_if_inst.rdata),
      .inval_all_i(inval_i));
   task end_sim;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task check(input logic [63:0] seen, input logic [63:0] want);
      total_checks++;
      if (seen !== want)
      begin
         error_cnt++;
         $display("unexpected at %0t: seen %h want %h", $time, seen, want);
      end
   endtask
   task tmo;
      error_cnt++;
      end_sim();
   endtask
   function automatic logic [63:0] rnd();
      logic [63:0] v;
      for (int i = 0; i < 64; i++)
      begin
         lfsr_r = {lfsr_r[30:0],
            lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
         v[i] = lfsr_r[0];
      end
      return v;
   endfunction
   task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= we;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hf;
      for (n = 0; n < 20 && ack_o !== 1'b1; n++)
         @(posedge clk_i);
      if (ack_o !== 1'b1)
         tmo();
      wbr = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      sel_i <= 4'h0;
   endtask
   task rdchk(input logic [3:0] a, input logic [31:0] x);
      wb(1'b0, a, 32'h0);
      check(wbr, x);
   endtask
   // note the expected answer, then hand the order to the source
   task op(input logic r, input logic [1:0] k, input logic [1:0] s,
      input logic [15:0] a, input logic [63:0] d, input logic [7:0] b,
      input logic [1:0] f, input logic [63:0] x);
      int n;
      exp_q.push_back({r, f, x});
      @(posedge clk_i);
      go_i <= 1'b1;
      rd_i <= r;
      kind_i <= k;
      size_i <= s;
      addr_i <= a;
      wdata_i <= d;
      strb_i <= b;
      @(posedge clk_i);
      go_i <= 1'b0;
      for (n = 0; n < 40 && done_o !== 1'b1; n++)
         @(posedge clk_i);
      if (done_o !== 1'b1)
         tmo();
   endtask
   always @(posedge clk_i)
   begin
      if (done_o === 1'b1)
      begin
         e = exp_q.pop_front();
         check(fault_o, e[64]);
         check(err_o, e[65]);
         if (e[66])
            check(rdata_o, e[63:0]);
      end
   end
   initial
   begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int sc = 0; sc < 3; sc++)
      begin
         wb(1'b1, 4'h0, 32'(sc) | 32'h4);
         rdchk(4'h0, 32'(sc) | 32'h4);
         d1 = rnd();
         op(0, `TCW_KIND_AXI, `TCW_SIZE_DWORD, 16'(sc * 8), d1, 8'hff,
            0, 0);
         op(1, `TCW_KIND_AXI, `TCW_SIZE_DWORD, 16'(sc * 8), 0, 0, 0, d1);
      end
      inval_i <= 1'b1;
      op(1, `TCW_KIND_AXI, `TCW_SIZE_DWORD, 16'h10, 0, 0, 0, d1);
      inval_i <= 1'b0;
      // 64-bit store mode: a half-width write merges with old data
      wb(1'b1, 4'h8, 32'h7);
      wb(1'b1, 4'h0, 32'he);
      d2 = rnd();
      op(0, `TCW_KIND_AXI, `TCW_SIZE_WORD, 16'h10, d2, 8'h0f, 0, 0);
      rdchk(4'h4, 32'h1);
      check(irq_o, 1'b1);
      wb(1'b1, 4'h4, 32'h1);
      rdchk(4'h4, 32'h0);
      check(irq_o, 1'b0);
      op(1, `TCW_KIND_AXI, `TCW_SIZE_DWORD, 16'h10, 0, 0, 0,
         {d1[63:32], d2[31:0]});
      for (int st = 0; st < 2; st++)
      begin
         wb(1'b1, 4'h0, st ? 32'h1e : 32'he);
         foreach (tbl[i])
            op(0, tbl[i][11:10], tbl[i][9:8], {8'h0, tbl[i][7:0]}, d2,
               8'hff, tbl[i][12] & (st[0] | tbl[i][11:10] != 2'h0),
               0);
      end
      wb(1'b1, 4'h8, 32'h0);
      rdchk(4'h4, 32'h3);
      check(irq_o, 1'b0);
      wb(1'b1, 4'h8, 32'h2);
      rdchk(4'h4, 32'h3);
      check(irq_o, 1'b1);
      wb(1'b1, 4'h4, 32'h3);
      rdchk(4'h4, 32'h0);
      check(irq_o, 1'b0);
      // enable held low: the read must wait for it
      en_i <= 1'b0;
      fork
         op(1, `TCW_KIND_AXI, `TCW_SIZE_DWORD, 16'h10, 0, 0, 0,
            {d1[63:32], d2[31:0]});
         begin
            repeat (6) @(posedge clk_i);
            en_i <= 1'b1;
         end
      join
      // partial write without rmw: upper lanes get stale check bits
      wb(1'b1, 4'h0, 32'h6);
      d2 = {d1[63:32] ^ 32'h01010101, d2[31:0]};
      op(0, `TCW_KIND_AXI, `TCW_SIZE_WORD, 16'h10, d2, 8'h0f, 0, 0);
      inval_i <= 1'b1;
      op(1, `TCW_KIND_AXI, `TCW_SIZE_DWORD, 16'h10, 0, 0, 0, d2);
      inval_i <= 1'b0;
      op(1, `TCW_KIND_AXI, `TCW_SIZE_DWORD, 16'h10, 0, 0, 2'h2, d2);
      rdchk(4'h4, 32'h4);
      wb(1'b1, 4'h4, 32'h4);
      rdchk(4'h4, 32'h0);
      rdchk(4'hc, 32'h0);
      end_sim();
   end
endmodule
`default_nettype wire
